// [hw/dtm_defines.svh]
// constants for the thermal and identity mode register block
`ifndef DTM_DEFINES_SVH
`define DTM_DEFINES_SVH
`define DTM_ADDR_IO_CONFIG 8'h03
`define DTM_ADDR_THERMAL 8'h04
`define DTM_ADDR_MAKER 8'h05
`define DTM_FLAG_BIT 7
`define DTM_DRIVE_RESET 4'h6
`define DTM_RATE_RESET 3'h3
`define DTM_RATE_LOW_LIMIT 3'h0
`define DTM_RATE_X4 3'h1
`define DTM_RATE_X2 3'h2
`define DTM_RATE_X1 3'h3
`define DTM_RATE_HALF 3'h4
`define DTM_RATE_QTR 3'h5
`define DTM_RATE_QTR_DERATE 3'h6
`define DTM_RATE_HIGH_LIMIT 3'h7
`define DTM_HOT_BIT 2
`endif

// [hw/dtm_pkg.sv]
// types for the thermal and identity mode register block
package dtm_pkg;
  typedef enum logic [1:0] {
    DTM_IDLE = 2'b00,
    DTM_ANSWER = 2'b01
  } dtm_state_e;
  typedef struct packed {
    logic [3:0] drive_strength_select;
    logic [2:0] refresh_rate_field;
    logic temperature_update_flag;
    logic [7:0] rd_data;
    logic rd_valid;
    logic derate;
    logic out_of_range;
    dtm_state_e state;
  } dtm_state_s;
endpackage

// [hw/dtm_mrw_if.sv]
// request carrier between the command decoder and the register bank
`timescale 1ns/1ps
interface dtm_mrw_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  modport src (output wr, rd, addr, wdata);
  modport dst (input wr, rd, addr, wdata);
endinterface

// [hw/dtm_req_decode.sv]
// registers the mode register command strobes into the carrier
`timescale 1ns/1ps
module dtm_req_decode (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // raw command
  input wire logic mrw_i,
  input wire logic mrr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  // registered request
  dtm_mrw_if.src req
);
  // one stage of registering, a write wins over a read
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      req.addr <= 8'h00;
      req.wdata <= 8'h00;
    end else begin
      req.wr <= mrw_i;
      req.rd <= mrr_i & ~mrw_i;
      req.addr <= addr_i;
      req.wdata <= wdata_i;
    end
  end
endmodule

// [hw/dtm_regs.sv]
// thermal status, maker code and drive strength mode registers
// Operation
// - refresh rate code 000 means low limit, 111 means high limit
// - codes 001, 010, 011 mean multipliers 4, 2, 1
// - codes 100 and 101 mean 0.5 and 0.25, no timing derate
// - code 110 means 0.25 and the host must derate timing
// - update flag sets when the rate field changes since last read
// - a read of the thermal register clears the update flag
// - update flag is zero after power-up; rate field is undefined (reset here loads 011)
// - rate field bit 2 set means temperature above 85 C
// - thermal register answers at address 04, read only
// - drive strength select is low four bits of io config
// - address 05 returns a fixed eight bit maker code
`timescale 1ns/1ps
`include "dtm_defines.svh"
module dtm_regs import dtm_pkg::*; #(
  parameter logic [7:0] MAKER_CODE = 8'h5a // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // mode register commands
  input wire logic mrw_i,
  input wire logic mrr_i,
  input wire logic [7:0] mode_register_address_i,
  input wire logic [7:0] wdata_i,
  // temperature sensor code
  input wire logic [2:0] sensor_rate_i,
  // read answer
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // decoded status and drive setting
  output logic [3:0] drive_strength_select_o,
  output logic derate_o,
  output logic out_of_range_o
);
  dtm_state_s s;
  dtm_state_s next_s;
  dtm_mrw_if req ();

  // ***********************************************
  // request registering
  // ***********************************************
  dtm_req_decode u_dec (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .mrw_i(mrw_i),
    .mrr_i(mrr_i),
    .addr_i(mode_register_address_i),
    .wdata_i(wdata_i),
    .req(req)
  );

  // host must derate for code 110
  function automatic logic needs_derate(input logic [2:0] c);
    return c == `DTM_RATE_QTR_DERATE;
  endfunction

  // out-of-range codes
  function automatic logic limit_hit(input logic [2:0] c);
    return c == `DTM_RATE_LOW_LIMIT || c == `DTM_RATE_HIGH_LIMIT;
  endfunction

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    next_s.state = DTM_IDLE;
    // sensor code passes straight into the field
    next_s.refresh_rate_field = sensor_rate_i;
    next_s.derate = needs_derate(sensor_rate_i);
    next_s.out_of_range = limit_hit(sensor_rate_i);
    // only io config is writable
    if (req.wr && req.addr == `DTM_ADDR_IO_CONFIG) begin
      next_s.drive_strength_select = req.wdata[3:0];
    end
    if (req.rd) begin
      next_s.rd_valid = 1'b1;
      next_s.state = DTM_ANSWER;
      unique case (req.addr)
        `DTM_ADDR_THERMAL: begin
          // old flag value returned, then cleared
          next_s.rd_data = {s.temperature_update_flag, 4'h0,
                            s.refresh_rate_field};
          next_s.temperature_update_flag = 1'b0;
        end
        `DTM_ADDR_MAKER: next_s.rd_data = MAKER_CODE;
        default: next_s.rd_data = 8'h00;
      endcase
    end
    // a change wins over a same-cycle clear
    if (sensor_rate_i != s.refresh_rate_field) begin
      next_s.temperature_update_flag = 1'b1;
    end
  end

  // ***********************************************
  // state register
  // ***********************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s.drive_strength_select <= `DTM_DRIVE_RESET;
      s.refresh_rate_field <= `DTM_RATE_RESET;
      s.temperature_update_flag <= 1'b0;
      s.rd_data <= 8'h00;
      s.rd_valid <= 1'b0;
      s.derate <= 1'b0;
      s.out_of_range <= 1'b0;
      s.state <= DTM_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flip-flops
  assign rd_data_o = s.rd_data;
  assign rd_valid_o = s.rd_valid;
  assign drive_strength_select_o = s.drive_strength_select;
  assign derate_o = s.derate;
  assign out_of_range_o = s.out_of_range;

  // ***********************************************
  // checks
  // ***********************************************
  // a thermal read with no rate change leaves the flag clear
  flag_clear_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    req.rd && req.addr == `DTM_ADDR_THERMAL
    && sensor_rate_i == s.refresh_rate_field
    |=> !s.temperature_update_flag)
    else $error("update flag not cleared by read");
  // any change of the rate code raises the flag next edge
  flag_set_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    sensor_rate_i != s.refresh_rate_field
    |=> s.temperature_update_flag)
    else $error("update flag not set on change");
  // flag comes up clear out of reset
  flag_reset_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    $past(reset_i) |-> !s.temperature_update_flag)
    else $error("update flag set after reset");
  // stored rate trails the sensor code by one edge
  rate_follow_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    !$past(reset_i) |-> s.refresh_rate_field == $past(sensor_rate_i))
    else $error("stored rate does not follow sensor");
  // thermal answer carries the flag from before the read
  old_flag_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    req.rd && req.addr == `DTM_ADDR_THERMAL
    |=> rd_valid_o
    && rd_data_o[`DTM_FLAG_BIT] == $past(s.temperature_update_flag))
    else $error("read data lost prior flag value");
  // thermal answer carries the stored rate code in its low bits
  rate_read_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    req.rd && req.addr == `DTM_ADDR_THERMAL
    |=> rd_data_o[`DTM_HOT_BIT:0] == $past(s.refresh_rate_field))
    else $error("thermal rate code wrong");
  // maker register answers with its fixed code
  maker_read_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    req.rd && req.addr == `DTM_ADDR_MAKER |=> rd_data_o == MAKER_CODE)
    else $error("maker code wrong");
  // a write to io config lands two edges after the command
  drive_write_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    mrw_i && mode_register_address_i == `DTM_ADDR_IO_CONFIG
    |=> ##1 drive_strength_select_o == $past(wdata_i[3:0], 2))
    else $error("drive strength not stored");
  // drive strength comes up at its reset code
  drive_reset_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    $past(reset_i) |-> drive_strength_select_o == `DTM_DRIVE_RESET)
    else $error("drive strength reset code wrong");
  // write and read together: only the write goes ahead
  write_wins_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    mrw_i && mrr_i |=> ##1 !rd_valid_o)
    else $error("read kept beside a write");
  // writes aimed at read-only places leave the drive field alone
  ro_write_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    req.wr && req.addr != `DTM_ADDR_IO_CONFIG
    |=> $stable(drive_strength_select_o))
    else $error("write to read-only register took effect");
  // derate is flagged exactly for the stored code 110
  derate_flag_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    s.refresh_rate_field == `DTM_RATE_QTR_DERATE |-> derate_o)
    else $error("derate not flagged");
  derate_only_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    derate_o |-> s.refresh_rate_field == `DTM_RATE_QTR_DERATE)
    else $error("derate flagged for a no-derate code");
  // out of range only for the two limit codes, and always for them
  limit_flag_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    out_of_range_o |-> s.refresh_rate_field inside
    {`DTM_RATE_LOW_LIMIT, `DTM_RATE_HIGH_LIMIT})
    else $error("out of range flag wrong");
  limit_seen_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    s.refresh_rate_field inside {`DTM_RATE_LOW_LIMIT, `DTM_RATE_HIGH_LIMIT}
    |-> out_of_range_o)
    else $error("limit code not flagged");
  // reserved thermal bits read as zero
  hot_field_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_valid_o && $past(req.addr) == `DTM_ADDR_THERMAL
    |-> rd_data_o[6:3] == 4'h0)
    else $error("reserved thermal bits not zero");
  // every read is answered one edge after it is registered
  read_answer_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    req.rd |=> rd_valid_o)
    else $error("read not answered");
  // no answer pulse without a read
  valid_pulse_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    !req.rd |=> !rd_valid_o)
    else $error("answer pulse without a read");
  // reads of unmapped places answer zero
  unmapped_read_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    req.rd && !(req.addr inside {`DTM_ADDR_THERMAL, `DTM_ADDR_MAKER})
    |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  // answer state and answer pulse agree
  answer_state_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    s.state == DTM_ANSWER |-> rd_valid_o)
    else $error("answer state without pulse");
endmodule

// [verification/dtm_host_model.sv]
// host controller model that issues mode register commands
`timescale 1ns/1ps
module dtm_host_model (
  // clock
  input wire logic clk_sys_i,
  // mode register command lines
  output logic mrw_o,
  output logic mrr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  // status the device reports back
  input wire logic derate_i,
  input wire logic out_of_range_i
);
  // quiet bus from time zero
  initial begin
    mrw_o = 1'b0;
    mrr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // one command per cycle, launched just after the edge
  task automatic issue(input logic wr, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    mrw_o = wr;
    mrr_o = ~wr;
    addr_o = a;
    wdata_o = d;
  endtask
  // release: strobes low, bus shows the inverse of its last value
  task automatic idle();
    @(posedge clk_sys_i) #1;
    mrw_o = 1'b0;
    mrr_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
  // write and read raised together, the read must be dropped
  task automatic both(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    mrw_o = 1'b1;
    mrr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
  endtask
  // extra core timing in eighths of a ns; 1.875 ns is 15
  logic [7:0] core_extra;
  // set while the device reports a temperature out of range
  logic hold_traffic;
  always @(posedge clk_sys_i) begin
    core_extra <= derate_i ? 8'h0f : 8'h00;
    hold_traffic <= out_of_range_i;
  end
endmodule

// [verification/tb.sv]
// self-checking bench for the thermal and identity mode registers
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
  logic clk_sys_i, reset_i, mrw, mrr, rd_valid, derate, oor;
  logic [7:0] addr, wdata, rd_data;
  logic [3:0] drive;
  logic [2:0] sensor;
  logic [7:0] exp_q[$];
  int failures, samples_checked;
  // device and host model
  dtm_regs #(.MAKER_CODE(MAKER)) u_dut (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .mrw_i(mrw), .mrr_i(mrr),
    .mode_register_address_i(addr), .wdata_i(wdata),
    .sensor_rate_i(sensor), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .drive_strength_select_o(drive), .derate_o(derate),
    .out_of_range_o(oor));
  dtm_host_model u_host (.clk_sys_i(clk_sys_i), .mrw_o(mrw),
    .mrr_o(mrr), .addr_o(addr), .wdata_o(wdata), .derate_i(derate),
    .out_of_range_i(oor));
  // 50 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // read: note the expected answer, then issue
  task automatic read(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_host.issue(1'b0, a, 8'h00);
  endtask
  task automatic wrap_up();
    if (exp_q.size() != 0) failures++;
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // answer monitor takes the oldest note on each valid pulse
  always @(negedge clk_sys_i) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("rd_valid", 8'h01, 8'h00);
      else
        check("rd_data", rd_data, exp_q.pop_front());
    end
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    failures++;
    wrap_up();
  end
  // main sequence
  initial begin
    logic [7:0] d;
    logic lim;
    failures = 0;
    samples_checked = 0;
    reset_i = 1'b1;
    sensor = 3'h3;
    void'($urandom(99672));
    repeat (6) @(posedge clk_sys_i);
    #1 reset_i = 1'b0;
    check("drive", {4'h0, drive}, 8'h06);
    read(8'h04, 8'h03);
    u_host.idle();
    // every rate code, each read twice back to back
    for (int i = 0; i < 8; i++) begin
      sensor = i[2:0];
      repeat (3) @(posedge clk_sys_i);
      #1 check("derate", {7'h0, derate}, {7'h0, i == 6});
      check("range", {7'h0, oor}, {7'h0, i == 0 || i == 7});
      lim = i == 0 || i == 7;
      check("hold", {7'h0, u_host.hold_traffic}, {7'h0, lim});
      check("extra", u_host.core_extra, i == 6 ? 8'h0f : 8'h00);
      read(8'h04, {1'b1, 4'h0, i[2:0]});
      read(8'h04, {1'b0, 4'h0, i[2:0]});
      u_host.idle();
    end
    // mid-run reset: flag raised by a change, then cleared by reset
    sensor = 3'h3;
    repeat (2) @(posedge clk_sys_i);
    #1 reset_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 reset_i = 1'b0;
    check("drive", {4'h0, drive}, 8'h06);
    read(8'h04, 8'h03);
    u_host.idle();
    // random drive write, then writes at read-only places
    d = 8'($urandom());
    u_host.issue(1'b1, 8'h03, d);
    u_host.idle();
    @(posedge clk_sys_i) #1;
    check("drive", {4'h0, drive}, {4'h0, d[3:0]});
    // write and read together: the write lands, no answer comes
    u_host.both(8'h03, ~d);
    u_host.idle();
    @(posedge clk_sys_i) #1;
    check("drive", {4'h0, drive}, {4'h0, ~d[3:0]});
    u_host.issue(1'b1, 8'h04, d);
    u_host.issue(1'b1, 8'h05, d);
    read(8'h04, 8'h03);
    read(8'h05, MAKER);
    read(8'h06, 8'h00);
    u_host.idle();
    repeat (4) @(posedge clk_sys_i);
    #1 check("drive", {4'h0, drive}, {4'h0, ~d[3:0]});
    wrap_up();
  end
endmodule
